/* File: src/bpa_pin_sync.sv */
`timescale 1ns/1ns
module bpa_pin_sync
  import bpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  bpa_sync_if.dst bus
);

  logic [7:0] meta_ff;
  logic [7:0] nxt_meta;
  logic [7:0] sync_ff;
  logic [7:0] nxt_sync;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_meta = bus.raw;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign bus.synced = sync_ff;

endmodule

/* File: src/bpa_pkg.sv */
package bpa_pkg;

  localparam int BPA_W = 8;

  // Register byte addresses on the APB.
  localparam logic [11:0] BPA_ADDR_PIN_LEVEL = 12'h000;
  localparam logic [11:0] BPA_ADDR_DIRECTION = 12'h004;
  localparam logic [11:0] BPA_ADDR_ANALOG = 12'h008;
  localparam logic [11:0] BPA_ADDR_FUNC_SEL = 12'h00C;
  localparam logic [11:0] BPA_ADDR_OSC_MODE = 12'h010;

  // Values after reset.
  localparam logic [7:0] BPA_RST_DIRECTION = 8'hFF;
  localparam logic [7:0] BPA_RST_ANALOG = 8'hFF;
  localparam logic [7:0] BPA_RST_LATCH = 8'h00;
  localparam logic [7:0] BPA_RST_FUNC_SEL = 8'h00;
  localparam logic [2:0] BPA_RST_OSC_MODE = 3'h0;

  // Pins that can be analog inputs, and the input-only pin.
  localparam logic [7:0] BPA_ANALOG_PINS = 8'h2F;
  localparam int BPA_INPUT_ONLY_PIN = 3;

  // Field positions inside the alternate function select register.
  localparam int BPA_SEL_PIN4_LSB = 0;
  localparam int BPA_SEL_PIN5_LSB = 2;
  localparam int BPA_SEL_OSC_LSB = 4;

  // Oscillator modes.
  localparam logic [2:0] BPA_OSC_LOW_POWER = 3'h0;
  localparam logic [2:0] BPA_OSC_CRYSTAL = 3'h1;
  localparam logic [2:0] BPA_OSC_HIGH_SPEED = 3'h2;

  // Function choices for pins 4 and 5.
  typedef enum logic [1:0] {
    BPA_FN_GPIO = 2'h0,
    BPA_FN_COMPARATOR = 2'h1,
    BPA_FN_PERIPH_IN = 2'h2
  } bpa_fn_t;

  localparam int BPA_SYNC_STAGES = 2;

endpackage

/* File: src/bpa_port.sv */
`timescale 1ns/1ns
module bpa_port
  import bpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] analog_enable,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  input wire logic osc_owns_pins,
  output logic timer_zero_clock_input,
  output logic slave_select_n
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic osc_crystal(input logic [2:0] mode);
    return (mode == BPA_OSC_LOW_POWER) || (mode == BPA_OSC_CRYSTAL) ||
           (mode == BPA_OSC_HIGH_SPEED);
  endfunction

  function automatic logic is_addr(input logic [11:0] a,
                                   input logic [11:0] r);
    return a == r;
  endfunction

  function automatic logic fn_is(input bpa_fn_t fn, input bpa_fn_t want);
    return fn == want;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  bpa_sync_if sync_bus ();

  assign sync_bus.raw = pin_in;

  bpa_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .bus(sync_bus)
  );

  logic [7:0] pin_level;
  assign pin_level = sync_bus.synced;

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] latch_ff;
  logic [7:0] nxt_latch;
  logic [7:0] dir_ff;
  logic [7:0] nxt_dir;
  logic [7:0] analog_select_mask_ff;
  logic [7:0] nxt_analog_select_mask;
  logic [7:0] fsel_ff;
  logic [7:0] nxt_fsel;
  logic [2:0] osc_ff;
  logic [2:0] nxt_osc;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] digital_read;
  logic [7:0] dir_read;
  logic [7:0] wbyte;
  logic crystal;
  bpa_fn_t fn4;
  bpa_fn_t fn5;

  // Every recognised oscillator code is a crystal or resonator mode.
  assign crystal = osc_crystal(osc_ff);
  // Codes outside the enum fall back to plain port use.
  assign fn4 = bpa_fn_t'(fsel_ff[BPA_SEL_PIN4_LSB +: 2]);
  assign fn5 = bpa_fn_t'(fsel_ff[BPA_SEL_PIN5_LSB +: 2]);

  assign mapped = is_addr(paddr, BPA_ADDR_PIN_LEVEL) ||
                  is_addr(paddr, BPA_ADDR_DIRECTION) ||
                  is_addr(paddr, BPA_ADDR_ANALOG) ||
                  is_addr(paddr, BPA_ADDR_FUNC_SEL) ||
                  is_addr(paddr, BPA_ADDR_OSC_MODE);

  // Zero-wait slave: the access phase always completes at once. Byte lane
  // zero carries every register, so a write without it changes nothing.
  assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  // Analog-selected pins read zero whatever their voltage.
  assign digital_read = pin_level & ~analog_select_mask_ff;

  // Pins 7 and 6 belong to the crystal in those modes, so software sees
  // them as inputs whatever it last wrote.
  always_comb begin
    dir_read = dir_ff;
    if (crystal) begin
      dir_read[7:6] = 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Every latch bit takes the written bit, input pin or not; the sampled
  // level never reaches the latch, so there is no read-modify-write hazard
  // for software to plan for.
  always_comb begin
    nxt_latch = latch_ff;
    if (wr_en && is_addr(paddr, BPA_ADDR_PIN_LEVEL)) begin
      for (int i = 0; i < BPA_W; i++) begin
        nxt_latch[i] = (wbyte[i] ^ digital_read[i]) ? wbyte[i]
                                                   : digital_read[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= BPA_RST_LATCH;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A one leaves the pad to the board.
  always_comb begin
    nxt_dir = dir_ff;
    if (wr_en && is_addr(paddr, BPA_ADDR_DIRECTION)) begin
      nxt_dir = wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= BPA_RST_DIRECTION;
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Bits of pins that have no analog path are held at zero.
  always_comb begin
    nxt_analog_select_mask = analog_select_mask_ff;
    if (wr_en && is_addr(paddr, BPA_ADDR_ANALOG)) begin
      nxt_analog_select_mask = wbyte & BPA_ANALOG_PINS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_select_mask_ff <= BPA_RST_ANALOG & BPA_ANALOG_PINS;
    end else begin
      analog_select_mask_ff <= nxt_analog_select_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_fsel = fsel_ff;
    if (wr_en && is_addr(paddr, BPA_ADDR_FUNC_SEL)) begin
      nxt_fsel = wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_ff <= BPA_RST_FUNC_SEL;
    end else begin
      fsel_ff <= nxt_fsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Codes above high speed select no crystal, leaving pins 6 and 7 free.
  always_comb begin
    nxt_osc = osc_ff;
    if (wr_en && is_addr(paddr, BPA_ADDR_OSC_MODE)) begin
      nxt_osc = wbyte[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ff <= BPA_RST_OSC_MODE;
    end else begin
      osc_ff <= nxt_osc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read data is captured in the setup cycle and then held, so it stands
  // through the access phase whatever the pins do meanwhile.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_en) begin
      nxt_rdata = '0;
      case (paddr)
        BPA_ADDR_PIN_LEVEL: nxt_rdata[7:0] = digital_read;
        BPA_ADDR_DIRECTION: nxt_rdata[7:0] = dir_read;
        BPA_ADDR_ANALOG: nxt_rdata[7:0] = analog_select_mask_ff;
        BPA_ADDR_FUNC_SEL: nxt_rdata[7:0] = fsel_ff;
        BPA_ADDR_OSC_MODE: nxt_rdata[2:0] = osc_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'h1;
  // An unmapped address is answered with an error and writes nothing.
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////

  // Per-pin overrides: a pad held off, or a peripheral value in place of
  // the latch. The analog select is deliberately left out here.
  logic osc_takes_pads;
  logic [7:0] pad_off;
  logic [7:0] alt_sel;
  logic [7:0] alt_val;
  logic [7:0] drv_val;
  logic [7:0] drv_en;

  // The oscillator block owns the pad drivers of pins 6 and 7 then.
  assign osc_takes_pads = crystal || osc_owns_pins ||
                          fsel_ff[BPA_SEL_OSC_LSB];

  // Nothing here stops software driving an analog pin; that stays its duty.
  always_comb begin
    pad_off = '0;
    alt_sel = '0;
    alt_val = '0;
    pad_off[BPA_INPUT_ONLY_PIN] = 1'h1;
    pad_off[4] = fn_is(fn4, BPA_FN_PERIPH_IN);
    alt_sel[4] = fn_is(fn4, BPA_FN_COMPARATOR);
    alt_val[4] = comparator_one_output;
    pad_off[5] = fn_is(fn5, BPA_FN_PERIPH_IN);
    alt_sel[5] = fn_is(fn5, BPA_FN_COMPARATOR);
    alt_val[5] = comparator_two_output;
    pad_off[7:6] = {2{osc_takes_pads}};
  end

  // A pad that is held off shows zero rather than a stale latch value.
  for (genvar g = 0; g < BPA_W; g++) begin : g_pad
    assign drv_en[g] = !dir_ff[g] && !pad_off[g];
    assign drv_val[g] = pad_off[g] ? 1'h0
                      : alt_sel[g] ? alt_val[g]
                      : latch_ff[g];
  end

  assign pin_out = drv_val;
  assign pin_oe = drv_en;
  assign analog_enable = analog_select_mask_ff;
  // Peripheral inputs take the synchronised level, never the raw pad.
  assign timer_zero_clock_input = fn_is(fn4, BPA_FN_PERIPH_IN) &&
                                  pin_level[4];
  assign slave_select_n = fn_is(fn5, BPA_FN_PERIPH_IN) ? pin_level[5]
                                                       : 1'h1;

endmodule

/* File: src/bpa_sync_if.sv */
`timescale 1ns/1ns
interface bpa_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

/* File: testbench/bpa_pins_model.sv */
`timescale 1ns/1ns
module bpa_pins_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] board,
  output logic [7:0] pin_in
);
  // Board drivers are weaker than the port, so an enabled driver wins.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

/* File: testbench/bpa_port_sva.sv */
`timescale 1ns/1ns
module bpa_port_sva
  import bpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] analog_enable,
  input wire logic osc_owns_pins,
  input wire logic timer_zero_clock_input,
  input wire logic slave_select_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_IN_ONLY: assert property (!pin_oe[3])
    else $error("input-only pin driven");
  AST_OSC_OWN: assert property (osc_owns_pins |-> pin_oe[7:6] == 2'h0)
    else $error("oscillator pins driven");
  AST_DIR: assert property (s_wr(BPA_ADDR_DIRECTION)
    |=> pin_oe[2:0] == ~$past(pwdata[2:0])) else $error("bad enables");
  AST_LATCH: assert property (s_wr(BPA_ADDR_PIN_LEVEL) |=>
    (pin_out[2:0] & pin_oe[2:0]) == ($past(pwdata[2:0]) & pin_oe[2:0]))
    else $error("latch not driven");
  AST_ANALOG: assert property (s_wr(BPA_ADDR_ANALOG) |=>
    analog_enable == ($past(pwdata[7:0]) & BPA_ANALOG_PINS))
    else $error("bad analog select");
  AST_AN_ZERO: assert property (s_rd(BPA_ADDR_PIN_LEVEL)
    |=> (prdata[7:0] & analog_enable) == 8'h00) else $error("analog read");
  AST_T0: assert property ($rose(timer_zero_clock_input)
    |-> $past(pin_in[4], 2)) else $error("timer clock rose early");
  AST_SS: assert property ($fell(slave_select_n)
    |-> !$past(pin_in[5], 2)) else $error("select fell early");
endmodule
bind bpa_port bpa_port_sva bpa_port_sva_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pin_in, .pin_out,
  .pin_oe, .analog_enable, .osc_owns_pins, .timer_zero_clock_input,
  .slave_select_n);

/* File: testbench/tb_bpa_port.sv */
`timescale 1ns/1ns
module tb_bpa_port
  import bpa_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, perr, osc_owns_pins = 1'h0;
  logic comparator_one_output = 1'h0, comparator_two_output = 1'h0;
  logic timer_zero_clock_input, slave_select_n;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] pin_in, pin_out, pin_oe, analog_enable, a, d, l, oe;
  logic [7:0] board = 8'hFF;
  int seed = 32'hF542C6C2;
  int mismatches = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  bpa_port bpa_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .analog_enable, .comparator_one_output,
    .comparator_two_output, .osc_owns_pins, .timer_zero_clock_input,
    .slave_select_n);
  bpa_pins_model bpa_pins_model_i (.pin_out, .pin_oe, .board, .pin_in);
  ////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  // Pins 6 and 7 lose their drivers to the oscillator; pin 3 has none.
  function logic [7:0] exp_oe(input logic [7:0] dir, input logic own);
    return ~dir & 8'hF7 & (own ? 8'h3F : 8'hFF);
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, BPA_ADDR_DIRECTION, 8'h0); chk(rd, 32'hFF);
    apb(1'h0, BPA_ADDR_ANALOG, 8'h0); chk(rd, 32'h2F);
    apb(1'h0, BPA_ADDR_PIN_LEVEL, 8'h0); chk(rd, 32'hD0);
    apb(1'h0, 12'h014, 8'h0);
    chk({rd[31:1], perr}, 32'h1);
    apb(1'h1, BPA_ADDR_DIRECTION, 8'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, BPA_ADDR_OSC_MODE, 8'(m));
      apb(1'h0, BPA_ADDR_DIRECTION, 8'h0);
      chk(rd, m < 3 ? 32'hC0 : 32'h0);
    end
    repeat (24) begin
      a = 8'($random(seed));
      d = 8'($random(seed)) | (a & 8'h2F);
      l = 8'($random(seed));
      board <= 8'($random(seed));
      osc_owns_pins <= 1'($random(seed));
      apb(1'h1, BPA_ADDR_ANALOG, a);
      apb(1'h1, BPA_ADDR_DIRECTION, d);
      apb(1'h1, BPA_ADDR_PIN_LEVEL, l);
      repeat (4) @(posedge pclk);
      oe = exp_oe(d, osc_owns_pins);
      chk(pin_oe, oe);
      chk(pin_out & oe, l & oe);
      apb(1'h0, BPA_ADDR_PIN_LEVEL, 8'h0);
      chk(rd, ((oe & l) | (~oe & board)) & ~(a & 8'h2F));
    end
    // Analog pins that software leaves as outputs still drive their latch.
    apb(1'h1, BPA_ADDR_ANALOG, 8'hFF);
    apb(1'h1, BPA_ADDR_DIRECTION, 8'h00);
    apb(1'h1, BPA_ADDR_PIN_LEVEL, 8'h27);
    repeat (2) @(posedge pclk);
    chk(pin_oe & 8'h27, 8'h27);
    chk(pin_out & 8'h27, 8'h27);
    pstrb <= 4'hE;
    apb(1'h1, BPA_ADDR_DIRECTION, 8'h5A);
    pstrb <= 4'hF;
    apb(1'h0, BPA_ADDR_DIRECTION, 8'h0);
    chk(rd, 32'h0);
    for (int f = 1; f < 3; f++) begin
      apb(1'h1, BPA_ADDR_DIRECTION, 8'h00);
      apb(1'h1, BPA_ADDR_FUNC_SEL, f == 1 ? 8'h05 : 8'h1A);
      repeat (3) begin
        comparator_one_output <= 1'($random(seed));
        comparator_two_output <= 1'($random(seed));
        board <= 8'($random(seed));
        repeat (4) @(posedge pclk);
        if (f == 1) begin
          chk(pin_out[5:4], {comparator_two_output,
            comparator_one_output});
        end else begin
          chk({slave_select_n, timer_zero_clock_input}, board[5:4]);
          chk(pin_oe[7:6], 2'h0);
          chk(pin_oe[5:4], 2'h0);
        end
      end
    end
    report_and_stop;
  end
endmodule
